// ===== hdl/pgc_pkg.sv
package pgc_pkg;

  // ==========================================================================
  // register addresses
  // ==========================================================================
  localparam logic [7:0]  GENERAL_CONTROL_ADDR = 8'h19;  // phy_general_control
  localparam logic [7:0]  IRQ_STATUS_ADDR      = 8'h30;  // sticky events, read only
  localparam logic [7:0]  IRQ_CLEAR_ADDR       = 8'h31;  // write one to clear, write only
  localparam logic [7:0]  IRQ_ENABLE_ADDR      = 8'h32;  // event enable mask
  localparam logic [7:0]  BLINK_RATE_ADDR      = 8'h33;  // blink rate select

  // ==========================================================================
  // field positions of phy_general_control
  // ==========================================================================
  localparam int AUTO_MDIX_BIT  = 15;  // auto crossover enable
  localparam int FORCE_MDIX_BIT = 14;  // forced pair swap
  localparam int PAUSE_RX_BIT   = 13;  // negotiated pause receive
  localparam int PAUSE_TX_BIT   = 12;  // negotiated pause transmit
  localparam int FDX100_BIT     = 11;  // auto-negotiated 100 full duplex link
  localparam int LED_BYPASS_BIT = 7;   // bypass led stretching
  localparam int LED_MODE_HI    = 6;   // led_mode_select msb
  localparam int LED_MODE_LO    = 5;   // led_mode_select lsb
  localparam int STATION_HI     = 4;   // station address msb, lsb at 0

  // advertisement / partner ability field positions
  localparam int AN_PAUSE_BIT   = 10;  // symmetric pause
  localparam int AN_ASM_BIT     = 11;  // asymmetric pause direction

  // interrupt event positions
  localparam int EV_LINK_UP     = 0;   // 100 full duplex link came up
  localparam int EV_LINK_DOWN   = 1;   // 100 full duplex link went away
  localparam int EV_PAUSE_CHG   = 2;   // pause resolution changed
  localparam int EV_W           = 3;   // number of events

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic       AUTO_MDIX_RST   = 1'h1;  // held until the strap is caught
  localparam logic       FORCE_MDIX_RST  = 1'h0;
  localparam logic       LED_BYPASS_RST  = 1'h0;
  localparam logic       LED_MODE_HI_RST = 1'h0;
  localparam logic       LED_MODE_LO_RST = 1'h0;  // held until the strap is caught
  localparam logic [1:0] BLINK_RATE_RST  = 2'h2;  // 5 Hz
  localparam logic [2:0] IRQ_ENABLE_RST  = 3'h0;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_KHZ        = 200000;  // SYS_CLK rate
  localparam int unsigned BLINK_20HZ_MS  = 50;      // on/off time per rate
  localparam int unsigned BLINK_10HZ_MS  = 100;
  localparam int unsigned BLINK_5HZ_MS   = 200;
  localparam int unsigned BLINK_2HZ_MS   = 500;
  localparam int unsigned STRETCH_MS     = 50;      // led pulse stretch
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;    // settle count; straps are caught on the fourth edge after release

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {LED_MODE_1, LED_MODE_2, LED_MODE_3} pgc_led_mode_type;

  typedef struct packed {
    logic       auto_mdix;        // auto crossover default
    logic       led_mode_lo;      // led_mode_select bit 0 default
    logic [4:0] station_address;  // station_address_strap
  } pgc_strap_type;

  typedef struct packed {
    logic link_good;        // link established
    logic speed_100;        // 100 Mb/s when set
    logic full_duplex;      // current duplex
    logic aneg_done;        // link made by auto-negotiation
    logic hcd_full_duplex;  // negotiated common mode is full duplex
    logic activity;         // tx or rx activity
    logic collision;        // collision seen
  } pgc_status_type;

  typedef struct packed {
    logic [2:0] drive;  // force enable: 2 speed, 1 link, 0 activity
    logic [2:0] value;  // forced level, same order
  } pgc_led_override_type;

endpackage

// ===== hdl/pgc_pulse_stretch.sv
// ============================================================================
// pulse stretcher for one indicator
// ============================================================================
module pgc_pulse_stretch #(
  parameter int unsigned HOLD_CYC = 1
) (
  input  wire logic SYS_CLK,
  input  wire logic SYS_RST,
  input  wire logic level_in,
  input  wire logic bypass,
  output logic      level_out
);

  logic [31:0] hold_q;  // cycles left to hold

  // reload on each input pulse, drain otherwise
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hold_q <= 32'h0;
    end else if (level_in) begin
      hold_q <= HOLD_CYC[31:0];
    end else if (hold_q != 32'h0) begin
      hold_q <= hold_q - 32'h1;
    end
  end

  // bypass shows the raw level with no stretch
  assign level_out = bypass ? level_in : (level_in || hold_q != 32'h0);

endmodule // pgc_pulse_stretch

// ===== hdl/pgc_general_control.sv
// Our own choice: the address-and-strobe port.
module pgc_general_control #(
  parameter int unsigned BLINK_20HZ_CYC = pgc_pkg::BLINK_20HZ_MS * pgc_pkg::CLK_KHZ,
  parameter int unsigned BLINK_10HZ_CYC = pgc_pkg::BLINK_10HZ_MS * pgc_pkg::CLK_KHZ,
  parameter int unsigned BLINK_5HZ_CYC  = pgc_pkg::BLINK_5HZ_MS * pgc_pkg::CLK_KHZ,
  parameter int unsigned BLINK_2HZ_CYC  = pgc_pkg::BLINK_2HZ_MS * pgc_pkg::CLK_KHZ,
  parameter int unsigned STRETCH_CYC    = pgc_pkg::STRETCH_MS * pgc_pkg::CLK_KHZ
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          SYS_RST,
  input  wire logic [7:0]                    REG_ADDR,
  input  wire logic [15:0]                   REG_WDATA,
  input  wire logic                          REG_WR,
  input  wire logic                          REG_RD,
  output logic      [15:0]                   REG_RDATA,
  input  wire pgc_pkg::pgc_strap_type        STRAP_IN,
  input  wire logic [15:0]                   LOCAL_ADVERTISEMENT_REG,
  input  wire logic [15:0]                   PARTNER_ABILITY_REG,
  input  wire pgc_pkg::pgc_status_type       LINK_STATUS,
  input  wire logic                          MDIX_AUTO_SWAP,
  input  wire pgc_pkg::pgc_led_override_type LED_OVERRIDE_REG,
  output logic                               AUTO_MDIX_EN,
  output logic                               PAIRS_CROSSED,
  output logic                               PAUSE_RX_EN,
  output logic                               PAUSE_TX_EN,
  output logic                               LINK_INDICATOR_OUT,
  output logic                               SPEED_INDICATOR_OUT,
  output logic                               ACTIVITY_INDICATOR_OUT,
  output logic                               IRQ
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic                    auto_mdix_q;     // bit 15
  logic                    force_mdix_q;    // bit 14
  logic                    led_bypass_q;    // bit 7
  logic [1:0]              led_mode_q;      // bits 6:5
  logic [4:0]              station_q;       // bits 4:0
  logic [1:0]              blink_rate_q;    // blink rate select
  logic [2:0]              irq_status_q;    // sticky events
  logic [2:0]              irq_enable_q;    // event mask
  pgc_pkg::pgc_strap_type  strap_meta_q;    // synchroniser stage one
  pgc_pkg::pgc_strap_type  strap_sync_q;    // synchroniser stage two
  logic [1:0]              settle_q;        // edges since reset release
  logic                    strap_taken_q;   // straps caught once
  logic                    pause_rx;        // resolved pause receive
  logic                    pause_tx;        // resolved pause transmit
  logic                    fdx100;          // negotiated 100 full link
  logic                    fdx100_q;        // previous fdx100
  logic [1:0]              pause_q;         // previous pause pair
  logic [2:0]              events;          // this cycle's events
  logic [31:0]             blink_cnt_q;     // blink half period counter
  logic [31:0]             blink_limit;     // selected half period
  logic                    blink_q;         // blink phase
  logic                    act_led;         // stretched activity
  logic                    col_led;         // stretched collision
  logic [2:0]              led_raw;         // 2 speed, 1 link, 0 activity
  pgc_pkg::pgc_led_mode_type led_mode;      // decoded mode
  logic [15:0]             control_word;    // assembled register image
  logic                    wr_ctrl;         // write to control register

  assign wr_ctrl = REG_WR && REG_ADDR == pgc_pkg::GENERAL_CONTROL_ADDR;

  // ==========================================================================
  // strap capture
  // ==========================================================================
  // straps come from pins: two flops before anything reads them
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      strap_meta_q <= '0;
      strap_sync_q <= '0;
    end else begin
      strap_meta_q <= STRAP_IN;
      strap_sync_q <= strap_meta_q;
    end
  end

  // wait until the synchroniser holds post-reset values
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      settle_q      <= 2'h0;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      if (settle_q == pgc_pkg::STRAP_SETTLE) begin
        strap_taken_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // station address only ever comes from the strap
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      station_q <= 5'h0;
    end else if (!strap_taken_q && settle_q == pgc_pkg::STRAP_SETTLE) begin
      station_q <= strap_sync_q.station_address;
    end
  end

  // ==========================================================================
  // writable control bits
  // ==========================================================================
  // strap capture overrides a write landing in the same edge
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      auto_mdix_q  <= pgc_pkg::AUTO_MDIX_RST;
      force_mdix_q <= pgc_pkg::FORCE_MDIX_RST;
      led_bypass_q <= pgc_pkg::LED_BYPASS_RST;
      led_mode_q   <= {pgc_pkg::LED_MODE_HI_RST, pgc_pkg::LED_MODE_LO_RST};
    end else if (!strap_taken_q && settle_q == pgc_pkg::STRAP_SETTLE) begin
      auto_mdix_q   <= strap_sync_q.auto_mdix;
      led_mode_q[0] <= strap_sync_q.led_mode_lo;
    end else if (wr_ctrl) begin
      auto_mdix_q  <= REG_WDATA[pgc_pkg::AUTO_MDIX_BIT];
      force_mdix_q <= REG_WDATA[pgc_pkg::FORCE_MDIX_BIT];
      led_bypass_q <= REG_WDATA[pgc_pkg::LED_BYPASS_BIT];
      led_mode_q   <= REG_WDATA[pgc_pkg::LED_MODE_HI:pgc_pkg::LED_MODE_LO];
      // bits 13:8 are status or reserved, not stored
    end
  end

  // blink rate select
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      blink_rate_q <= pgc_pkg::BLINK_RATE_RST;
    end else if (REG_WR && REG_ADDR == pgc_pkg::BLINK_RATE_ADDR) begin
      blink_rate_q <= REG_WDATA[1:0];
    end
  end

  // ==========================================================================
  // crossover
  // ==========================================================================
  // force wins over the auto detector's choice
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PAIRS_CROSSED <= 1'b0;
    end else begin
      PAIRS_CROSSED <= force_mdix_q || (auto_mdix_q && MDIX_AUTO_SWAP);
    end
  end

  assign AUTO_MDIX_EN = auto_mdix_q;

  // ==========================================================================
  // pause resolution and link status
  // ==========================================================================
  // standard symmetric / asymmetric pause table, gated by full duplex
  always_comb begin
    logic lp;
    logic la;
    logic pp;
    logic pa;
    lp = LOCAL_ADVERTISEMENT_REG[pgc_pkg::AN_PAUSE_BIT];
    la = LOCAL_ADVERTISEMENT_REG[pgc_pkg::AN_ASM_BIT];
    pp = PARTNER_ABILITY_REG[pgc_pkg::AN_PAUSE_BIT];
    pa = PARTNER_ABILITY_REG[pgc_pkg::AN_ASM_BIT];
    pause_rx = LINK_STATUS.hcd_full_duplex && lp && (pp || (la && pa));
    pause_tx = LINK_STATUS.hcd_full_duplex && pp && (lp || (la && pa))
               && !(lp && !pp);
  end

  // only a negotiated 100 full duplex link counts
  assign fdx100 = LINK_STATUS.link_good && LINK_STATUS.speed_100 && LINK_STATUS.full_duplex
                  && LINK_STATUS.aneg_done;

  // registered copies feed the pause outputs, the fdx100 read bit and the edge detect
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fdx100_q <= 1'b0;
      pause_q  <= 2'h0;
    end else begin
      fdx100_q <= fdx100;
      pause_q  <= {pause_rx, pause_tx};
    end
  end

  assign PAUSE_RX_EN = pause_q[1];
  assign PAUSE_TX_EN = pause_q[0];

  // ==========================================================================
  // interrupts
  // ==========================================================================
  always_comb begin
    events                        = 3'h0;
    events[pgc_pkg::EV_LINK_UP]   = fdx100 && !fdx100_q;
    events[pgc_pkg::EV_LINK_DOWN] = !fdx100 && fdx100_q;
    events[pgc_pkg::EV_PAUSE_CHG] = {pause_rx, pause_tx} != pause_q;
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_status_q <= 3'h0;
    end else if (REG_WR && REG_ADDR == pgc_pkg::IRQ_CLEAR_ADDR) begin
      irq_status_q <= (irq_status_q & ~REG_WDATA[2:0]) | events;
    end else begin
      irq_status_q <= irq_status_q | events;
    end
  end

  // event mask
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_enable_q <= pgc_pkg::IRQ_ENABLE_RST;
    end else if (REG_WR && REG_ADDR == pgc_pkg::IRQ_ENABLE_ADDR) begin
      irq_enable_q <= REG_WDATA[2:0];
    end
  end

  assign IRQ = |(irq_status_q & irq_enable_q);

  // ==========================================================================
  // blink generator
  // ==========================================================================
  always_comb begin
    case (blink_rate_q)
      2'h0:    blink_limit = BLINK_20HZ_CYC[31:0];
      2'h1:    blink_limit = BLINK_10HZ_CYC[31:0];
      2'h2:    blink_limit = BLINK_5HZ_CYC[31:0];
      default: blink_limit = BLINK_2HZ_CYC[31:0];
    endcase
  end

  // free running; a rate change applies to the current half period, ending it at once if the count has passed the new limit
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q + 32'h1 >= blink_limit) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // ==========================================================================
  // led stretching and mode mux
  // ==========================================================================
  pgc_pulse_stretch #(
    .HOLD_CYC (STRETCH_CYC)
  ) u_act_stretch (
    .SYS_CLK   (SYS_CLK),
    .SYS_RST   (SYS_RST),
    .level_in  (LINK_STATUS.activity),
    .bypass    (led_bypass_q),
    .level_out (act_led)
  );

  pgc_pulse_stretch #(
    .HOLD_CYC (STRETCH_CYC)
  ) u_col_stretch (
    .SYS_CLK   (SYS_CLK),
    .SYS_RST   (SYS_RST),
    .level_in  (LINK_STATUS.collision),
    .bypass    (led_bypass_q),
    .level_out (col_led)
  );

  // bit 0 set selects mode 1 whatever bit 1 holds
  always_comb begin
    if (led_mode_q[0]) begin
      led_mode = pgc_pkg::LED_MODE_1;
    end else if (led_mode_q[1]) begin
      led_mode = pgc_pkg::LED_MODE_3;
    end else begin
      led_mode = pgc_pkg::LED_MODE_2;
    end
  end

  // speed led left undefined in modes 1 and 3: shows speed there too
  always_comb begin
    case (led_mode)
      pgc_pkg::LED_MODE_1: begin
        led_raw = {LINK_STATUS.speed_100, LINK_STATUS.link_good, act_led};
      end
      pgc_pkg::LED_MODE_2: begin
        led_raw = {LINK_STATUS.speed_100, LINK_STATUS.link_good, col_led};
      end
      pgc_pkg::LED_MODE_3: begin
        led_raw = {LINK_STATUS.speed_100, act_led && blink_q, LINK_STATUS.full_duplex};
      end
      default: begin
        led_raw = 3'h0;
      end
    endcase
  end

  // manual override from the led override register wins over the mode
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SPEED_INDICATOR_OUT    <= 1'b0;
      LINK_INDICATOR_OUT     <= 1'b0;
      ACTIVITY_INDICATOR_OUT <= 1'b0;
    end else begin
      {SPEED_INDICATOR_OUT, LINK_INDICATOR_OUT, ACTIVITY_INDICATOR_OUT} <=
        (LED_OVERRIDE_REG.drive & LED_OVERRIDE_REG.value) | (~LED_OVERRIDE_REG.drive & led_raw);
    end
  end

  // ==========================================================================
  // read path
  // ==========================================================================
  always_comb begin
    control_word                          = 16'h0000;  // reserved 10:8 stay zero
    control_word[pgc_pkg::AUTO_MDIX_BIT]  = auto_mdix_q;
    control_word[pgc_pkg::FORCE_MDIX_BIT] = force_mdix_q;
    control_word[pgc_pkg::PAUSE_RX_BIT]   = pause_q[1];
    control_word[pgc_pkg::PAUSE_TX_BIT]   = pause_q[0];
    control_word[pgc_pkg::FDX100_BIT]     = fdx100_q;
    control_word[pgc_pkg::LED_BYPASS_BIT] = led_bypass_q;
    control_word[pgc_pkg::LED_MODE_HI:pgc_pkg::LED_MODE_LO] = led_mode_q;
    control_word[pgc_pkg::STATION_HI:0]   = station_q;
  end

  // data stand one cycle after the read strobe, zero otherwise
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        pgc_pkg::GENERAL_CONTROL_ADDR: REG_RDATA <= control_word;
        pgc_pkg::IRQ_STATUS_ADDR:      REG_RDATA <= {13'h0000, irq_status_q};
        pgc_pkg::IRQ_ENABLE_ADDR:      REG_RDATA <= {13'h0000, irq_enable_q};
        pgc_pkg::BLINK_RATE_ADDR:      REG_RDATA <= {14'h0000, blink_rate_q};
        default:                       REG_RDATA <= 16'h0000;  // unmapped and clear reg
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

endmodule // pgc_general_control

// ===== test/pgc_link_partner.sv
// ============================================================================
// far side: negotiated abilities and line status
module pgc_link_partner (
  input  wire logic [3:0]           pause_code,  // local pause, local asym, peer pause, peer asym
  input  wire logic [6:0]           link_flags,  // line status, struct order
  output logic      [15:0]          local_adv,   // our advertisement
  output logic      [15:0]          peer_adv,    // partner ability
  output pgc_pkg::pgc_status_type   status       // line status to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  // only the pause and direction bits carry meaning here
  always_comb begin
    local_adv = {4'h0, pause_code[2], pause_code[3], 10'h000};
    peer_adv  = {4'h0, pause_code[0], pause_code[1], 10'h000};
    status    = pgc_pkg::pgc_status_type'(link_flags);
  end
endmodule // pgc_link_partner

// ===== test/pgc_general_control_asserts.sv
// ============================================================================
// port checker
module pgc_general_control_chk (
  input wire logic                          SYS_CLK,
  input wire logic                          SYS_RST,
  input wire logic [7:0]                    REG_ADDR,
  input wire logic [15:0]                   REG_WDATA,
  input wire logic                          REG_WR,
  input wire logic                          REG_RD,
  input wire logic [15:0]                   REG_RDATA,
  input wire pgc_pkg::pgc_strap_type        STRAP_IN,
  input wire logic [15:0]                   LOCAL_ADVERTISEMENT_REG,
  input wire logic [15:0]                   PARTNER_ABILITY_REG,
  input wire pgc_pkg::pgc_status_type       LINK_STATUS,
  input wire logic                          MDIX_AUTO_SWAP,
  input wire pgc_pkg::pgc_led_override_type LED_OVERRIDE_REG,
  input wire logic                          AUTO_MDIX_EN,
  input wire logic                          PAIRS_CROSSED,
  input wire logic                          PAUSE_RX_EN,
  input wire logic                          PAUSE_TX_EN,
  input wire logic                          SPEED_INDICATOR_OUT,
  input wire logic                          IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // abilities and the 100 full duplex condition
  wire lp  = LOCAL_ADVERTISEMENT_REG[pgc_pkg::AN_PAUSE_BIT];
  wire la  = LOCAL_ADVERTISEMENT_REG[pgc_pkg::AN_ASM_BIT];
  wire pp  = PARTNER_ABILITY_REG[pgc_pkg::AN_PAUSE_BIT];
  wire pa  = PARTNER_ABILITY_REG[pgc_pkg::AN_ASM_BIT];
  wire h   = LINK_STATUS.hcd_full_duplex;
  wire fdx = &LINK_STATUS[6:3];  // link, 100, full, aneg
  // ==========================================================================
  // control register read, data standing now
  sequence s_rd_ctl;
    $past(REG_RD) && $past(REG_ADDR) == pgc_pkg::GENERAL_CONTROL_ADDR;
  endsequence
  a_reserved_zero: assert property (s_rd_ctl |-> REG_RDATA[10:8] == 3'h0)
    else $error("reserved bits not zero");
  a_auto_out: assert property (s_rd_ctl |-> REG_RDATA[15] == $past(AUTO_MDIX_EN))
    else $error("auto crossover bit wrong");
  a_pair_swap: assert property (s_rd_ctl |->
    PAIRS_CROSSED == (REG_RDATA[14] | REG_RDATA[15] & $past(MDIX_AUTO_SWAP))) else $error("pair crossing wrong");
  a_fdx100_read: assert property (s_rd_ctl |-> REG_RDATA[11] == $past(fdx, 2))
    else $error("100 full duplex bit wrong");
  a_station_read: assert property (s_rd_ctl |-> REG_RDATA[4:0] == $past(STRAP_IN.station_address))
    else $error("station address wrong");
  // pause follows the abilities one cycle later
  a_pause_rx: assert property (!$past(SYS_RST) |-> PAUSE_RX_EN == $past(h & lp & (pp | la & pa)))
    else $error("pause receive wrong");
  a_pause_tx: assert property (!$past(SYS_RST) |-> PAUSE_TX_EN == $past(h & pp & (lp | la & pa)))
    else $error("pause transmit wrong");
  a_speed_led: assert property (!$past(SYS_RST) && !$past(LED_OVERRIDE_REG.drive[2])
    |-> SPEED_INDICATOR_OUT == $past(LINK_STATUS.speed_100))
    else $error("speed indicator wrong");
  a_irq_masked: assert property ($past(REG_WR) && $past(REG_ADDR) == pgc_pkg::IRQ_ENABLE_ADDR
    && $past(REG_WDATA[2:0]) == 3'h0 |-> !IRQ) else $error("interrupt while all masked");
endmodule // pgc_general_control_chk

bind pgc_general_control pgc_general_control_chk u_chk (.*);

// ===== test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STR = 4;  // shortened stretch hold
  logic SYS_CLK, SYS_RST, REG_WR, REG_RD, MDIX_AUTO_SWAP, AUTO_MDIX_EN, PAIRS_CROSSED, IRQ;
  logic PAUSE_RX_EN, PAUSE_TX_EN, LINK_INDICATOR_OUT, SPEED_INDICATOR_OUT, ACTIVITY_INDICATOR_OUT;
  wire [2:0] leds = {LINK_INDICATOR_OUT, SPEED_INDICATOR_OUT, ACTIVITY_INDICATOR_OUT};
  logic [7:0]  REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, LOCAL_ADVERTISEMENT_REG, PARTNER_ABILITY_REG, d;
  logic [3:0]  pause_code;  // far side abilities
  logic [6:0]  link_flags;  // far side line status
  int          mismatches = 0, total_checks = 0, n;
  pgc_pkg::pgc_strap_type       STRAP_IN;
  pgc_pkg::pgc_status_type      LINK_STATUS;
  pgc_pkg::pgc_led_override_type LED_OVERRIDE_REG;
  // short counts keep the run brief
  pgc_general_control #(.BLINK_20HZ_CYC(8), .BLINK_10HZ_CYC(16), .BLINK_5HZ_CYC(32), .BLINK_2HZ_CYC(64),
    .STRETCH_CYC(STR)) u_dut (.*);
  pgc_link_partner u_far (.pause_code(pause_code), .link_flags(link_flags), .local_adv(LOCAL_ADVERTISEMENT_REG),
    .peer_adv(PARTNER_ABILITY_REG), .status(LINK_STATUS));
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  // ==========================================================================
  // helpers
  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // settle just after an edge
  task automatic cyc(int k);
    repeat (k) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= v;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rd(8'h19); chk("ctl", d, 16'h0035);
    chk("auto", AUTO_MDIX_EN, 16'h0);
    rd(8'h33); chk("rate", d, 16'h0002);
    rd(8'h7F); chk("unmapped", d, 16'h0);
  endtask
  task automatic t_rw();
    wr(8'h19, 16'hFFFF); rd(8'h19); chk("ctl ro", d, 16'hC0F5);
    chk("forced", PAIRS_CROSSED, 16'h1);
    wr(8'h19, 16'h8000); MDIX_AUTO_SWAP <= 1'b1; cyc(2);
    chk("auto swap", PAIRS_CROSSED, 16'h1);
    wr(8'h19, 16'h0000); cyc(2);
    chk("no swap", PAIRS_CROSSED, 16'h0);
  endtask
  // every ability combination, with and without full duplex
  task automatic t_pause();
    logic [4:0] i;
    for (int k = 0; k < 32; k++) begin
      i = 5'(k);
      pause_code <= i[3:0]; link_flags <= {4'h0, i[4], 2'h0};
      cyc(2); rd(8'h19);
      chk("prx", d[13], i[4] & i[3] & (i[1] | i[2] & i[0]));
      chk("ptx", d[12], i[4] & i[1] & (i[3] | i[2] & i[0]));
    end
  endtask
  task automatic t_fdx_irq();
    wr(8'h31, 16'h0007); wr(8'h32, 16'h0001); link_flags <= 7'h7C; cyc(3);
    rd(8'h19); chk("fdx up", d[11], 16'h1);
    rd(8'h30); chk("ev up", d, 16'h0001);
    chk("irq", IRQ, 16'h1);
    wr(8'h31, 16'h0001); cyc(1); chk("irq clr", IRQ, 16'h0);
    link_flags <= 7'h6C; cyc(3);
    rd(8'h19); chk("fdx dn", d[11], 16'h0);
    chk("irq masked", IRQ, 16'h0);
    rd(8'h30); chk("ev dn", d, 16'h0002);
    wr(8'h32, 16'h0002); cyc(1); chk("irq dn", IRQ, 16'h1);
    wr(8'h32, 16'h0000); cyc(1); chk("irq off", IRQ, 16'h0);
  endtask
  task automatic t_leds();
    wr(8'h19, 16'h0080); link_flags <= 7'h41; cyc(3);
    chk("m2 col", leds, 16'h5);
    link_flags <= 7'h60; cyc(3);
    chk("m2 spd", leds, 16'h6);
    wr(8'h19, 16'h00A0); link_flags <= 7'h02; cyc(3);
    chk("m1", leds, 16'h1);
    wr(8'h19, 16'h00C0); link_flags <= 7'h10; cyc(3);
    chk("m3 dup", {LINK_INDICATOR_OUT, ACTIVITY_INDICATOR_OUT}, 16'h1);
    LED_OVERRIDE_REG <= 6'h08; cyc(2); chk("ovr", ACTIVITY_INDICATOR_OUT, 16'h0);
    LED_OVERRIDE_REG <= 6'h00;
    // one cycle activity pulse, stretched then bypassed
    for (int b = 0; b < 2; b++) begin
      wr(8'h19, b ? 16'h00A0 : 16'h0020); cyc(STR + 3);
      link_flags <= 7'h02; cyc(1); link_flags <= 7'h00; cyc(2);
      chk("stretch", ACTIVITY_INDICATOR_OUT, 16'(b == 0));
      cyc(STR + 3); chk("stretch end", ACTIVITY_INDICATOR_OUT, 16'h0);
    end
  endtask
  // blink half period per rate select
  task automatic t_blink();
    logic p;
    wr(8'h19, 16'h00C0); link_flags <= 7'h02;
    for (int r = 0; r < 4; r++) begin
      wr(8'h33, 16'(r)); cyc(2);
      for (int g = 0; g < 2; g++) begin
        p = LINK_INDICATOR_OUT; n = 0;
        while (LINK_INDICATOR_OUT === p && n < 300) begin cyc(1); n++; end
        if (n >= 300) begin mismatches++; tally_and_finish(); end
      end
      chk("blink", 16'(n), 16'(8 << r));
    end
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    SYS_RST = 1'b1; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 8'h00; REG_WDATA = 16'h0000;
    STRAP_IN = 7'h35; MDIX_AUTO_SWAP = 1'b0; LED_OVERRIDE_REG = 6'h00;
    pause_code = 4'h0; link_flags = 7'h00;
    repeat (6) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    cyc(6);
    t_reset(); t_rw(); t_pause(); t_fdx_irq(); t_leds(); t_blink();
    tally_and_finish();
  end
endmodule // tb_top
